// File: inc/ipc_consts.svh
// Constants for the card configuration logic
`ifndef IPC_CONSTS_SVH
`define IPC_CONSTS_SVH
`define IPC_EE_STA0     6'h00
`define IPC_EE_STA2     6'h02
`define IPC_EE_CFGAB    6'h0e
`define IPC_EE_MODE     6'h0f
`define IPC_EE_VID0     6'h10
`define IPC_EE_VID1     6'h11
`define IPC_EE_SER0     6'h12
`define IPC_EE_SER1     6'h13
`define IPC_EE_CKSUM    6'h14
`define IPC_EE_RES0     6'h15
`define IPC_EE_RESN     6'h3f
`define IPC_MODE_JL     8'h4a
`define IPC_MODE_PNP    8'h50
`define IPC_KEY_LEN     6'h20
`define IPC_STD_SEED    8'h6a
`define IPC_VND_SEED    8'h39
`define IPC_CFGD_RST    8'h00
`define IPC_CSN_NONE    8'h00
`endif

// File: inc/ipc_pkg.sv
// Types for the card configuration logic
package ipc_pkg;
  typedef enum logic [1:0] {WAIT_KEY, SLEEP, ISOLATE, CONFIG} ipc_state_e;
  typedef enum logic [1:0] {MODE_AUTO, MODE_JL, MODE_PNP} ipc_mode_e;
endpackage : ipc_pkg

// File: hdl/ipc_key_match.sv
// Initiation key recogniser: 32 address-port writes of an LFSR run
`timescale 1ns/1ps
`default_nettype none
`include "ipc_consts.svh"
module ipc_key_match #(
  parameter logic [7:0] SEED = `IPC_STD_SEED
) (
  input  wire logic       clk,  // Device clock
  input  wire logic       rst,  // Sync reset
  input  wire logic       arm,  // Card is waiting for a key
  input  wire logic       wr,   // Address port write
  input  wire logic [7:0] data, // Written byte
  output logic            hit   // Full key seen, one cycle
);
  logic [7:0] lfsr_q, lfsr_d;
  logic [5:0] cnt_q, cnt_d;
  logic       hit_d;

  // --------------------------------------------------------------
  // Key sequencing
  // --------------------------------------------------------------
  // A wrong byte restarts the match, so any stray write resyncs
  always_comb
  begin
    lfsr_d = lfsr_q;
    cnt_d  = cnt_q;
    hit_d  = 1'b0;
    if (!arm)
    begin
      lfsr_d = SEED;
      cnt_d  = 6'h00;
    end
    else if (wr)
    begin
      if (data == lfsr_q)
      begin
        lfsr_d = {lfsr_q[1] ^ lfsr_q[0], lfsr_q[7:1]};
        cnt_d  = cnt_q + 6'h01;
        if (cnt_q == `IPC_KEY_LEN - 6'h01)
        begin
          hit_d  = 1'b1;
          lfsr_d = SEED;
          cnt_d  = 6'h00;
        end
      end
      // A stray byte that is itself the seed opens a fresh run, since
      // the other key's last byte may equal this seed
      else if (data == SEED)
      begin
        lfsr_d = {SEED[1] ^ SEED[0], SEED[7:1]};
        cnt_d  = 6'h01;
      end
      else
      begin
        lfsr_d = SEED;
        cnt_d  = 6'h00;
      end
    end
  end

  // Registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lfsr_q <= SEED;
      cnt_q  <= 6'h00;
      hit    <= 1'b0;
    end
    else
    begin
      lfsr_q <= lfsr_d;
      cnt_q  <= cnt_d;
      hit    <= hit_d;
    end
  end
endmodule : ipc_key_match
`default_nettype wire

// File: hdl/ipc_ee_loader.sv
// EEPROM word fetcher: boot image after reset, then resource reads
`timescale 1ns/1ps
`default_nettype none
`include "ipc_consts.svh"
module ipc_ee_loader (
  input  wire logic        clk,       // Device clock
  input  wire logic        rst,       // Sync reset
  output logic             ee_req,    // Word request, level
  output logic [5:0]       ee_addr,   // Word address
  input  wire logic        ee_valid,  // Word returned, pulse
  input  wire logic [15:0] ee_data,   // Returned word
  output logic             w_valid,   // Boot word strobe
  output logic [5:0]       w_addr,    // Boot word address
  output logic [15:0]      w_data,    // Boot word data
  output logic             done,      // Boot image loaded
  input  wire logic        res_req,   // Resource read, pulse
  input  wire logic [5:0]  res_idx,   // Resource word index
  output logic             res_valid, // Resource word strobe
  output logic [15:0]      res_data   // Resource word
);
  logic        req_d, done_d, wv_d, rv_d;
  logic [5:0]  addr_d, wa_d;
  logic [15:0] wd_d, rd_d;
  logic [6:0]  ra;

  // --------------------------------------------------------------
  // Fetch sequencing
  // --------------------------------------------------------------
  // Words 03h-0dh hold nothing this block needs, so they are skipped
  always_comb
  begin
    ra     = {1'b0, `IPC_EE_RES0} + {1'b0, res_idx};
    req_d  = ee_req;
    addr_d = ee_addr;
    done_d = done;
    wv_d   = 1'b0;
    wa_d   = w_addr;
    wd_d   = w_data;
    rv_d   = 1'b0;
    rd_d   = res_data;
    if (ee_req && ee_valid)
    begin
      if (!done)
      begin
        wv_d = 1'b1;
        wa_d = ee_addr;
        wd_d = ee_data;
        if (ee_addr == `IPC_EE_CKSUM)
        begin
          req_d  = 1'b0;
          done_d = 1'b1;
        end
        else if (ee_addr == `IPC_EE_STA2)
          addr_d = `IPC_EE_CFGAB;
        else
          addr_d = ee_addr + 6'h01;
      end
      else
      begin
        req_d = 1'b0;
        rv_d  = 1'b1;
        rd_d  = ee_data;
      end
    end
    else if (done && !ee_req && res_req)
    begin
      // Reads past the last resource word stick at the last word
      req_d  = 1'b1;
      addr_d = (ra > {1'b0, `IPC_EE_RESN}) ? `IPC_EE_RESN : ra[5:0];
    end
  end

  // Registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ee_req    <= 1'b1;
      ee_addr   <= `IPC_EE_STA0;
      done      <= 1'b0;
      w_valid   <= 1'b0;
      w_addr    <= `IPC_EE_STA0;
      w_data    <= 16'h0000;
      res_valid <= 1'b0;
      res_data  <= 16'h0000;
    end
    else
    begin
      ee_req    <= req_d;
      ee_addr   <= addr_d;
      done      <= done_d;
      w_valid   <= wv_d;
      w_addr    <= wa_d;
      w_data    <= wd_d;
      res_valid <= rv_d;
      res_data  <= rd_d;
    end
  end
endmodule : ipc_ee_loader
`default_nettype wire

// File: hdl/ipc_card_cfg.sv
// Card-side plug and play state machine, keys, modes and config bytes
//
// What this block does
// [RL1] Four card states: wait, sleep, isolate, config
// [RL2] Reset drive: wait for key, number zero
// [RL3] Wait-for-key command returns to wait state
// [RL4] Both number resets clear it, keep state
// [RL5] Mode byte 4a jumperless, 50 pnp, else auto
// [RL6] Mode latched only at hardware reset
// [RL7] Auto mode: jumperless unless software configures
// [RL8] Jumperless ignores standard software configuration
// [RL9] Pnp mode starts disabled until host programs
// [RL10] Commands accepted only after full 32-write key
// [RL11] Standard key all cards, vendor key ours
// [RL12] Vendor id, serial, checksum from words 10h-14h
// [RL13] Resource data from words 15h to 3fh
// [RL14] Vendor key any mode, standard pnp and auto only
// [RL15] Software writes update config bytes until reset
// [RL16] Station address and config bytes after reset
// [RL17] Isolation and numbering per published protocol
`timescale 1ns/1ps
`default_nettype none
`include "ipc_consts.svh"
module ipc_card_cfg (
  input  wire logic        REF_CLK,     // 125 MHz device clock
  input  wire logic        RST,         // Bus reset drive, active high
  input  wire logic        ADDR_WR,     // Address port write strobe
  input  wire logic [7:0]  ADDR_DATA,   // Address port byte
  input  wire logic        CMD_WAIT_KEY, // Wait-for-key command
  input  wire logic        CMD_RST_STD, // Standard number reset
  input  wire logic        CMD_RST_VND, // Vendor number reset
  input  wire logic        CMD_WAKE,    // Wake command
  input  wire logic        CMD_SET_CSN, // Set number command
  input  wire logic [7:0]  CMD_DATA,    // Command argument
  input  wire logic        ISO_LOST,    // Lost isolation compare
  input  wire logic        CFG_WR,      // Config byte write
  input  wire logic [1:0]  CFG_IDX,     // Config byte A..D
  input  wire logic [7:0]  CFG_DATA,    // Config byte value
  input  wire logic        ACT_WR,      // Activate write
  input  wire logic        ACT_DATA,    // Activate value
  input  wire logic        RES_REQ,     // Resource word read
  input  wire logic [5:0]  RES_IDX,     // Resource word index
  output logic             RES_VALID,   // Resource word strobe
  output logic [15:0]      RES_DATA,    // Resource word
  output logic             EE_REQ,      // EEPROM word request
  output logic [5:0]       EE_ADDR,     // EEPROM word address
  input  wire logic        EE_VALID,    // EEPROM word ready
  input  wire logic [15:0] EE_DATA,     // EEPROM word
  output logic [1:0]       STATE,       // Card state
  output logic [7:0]       CSN,         // Card select number
  output logic [1:0]       MODE,        // Operation mode
  output logic             LOAD_DONE,   // Boot image loaded
  output logic             CFG_ACTIVE,  // Resources usable
  output logic             HOST_CFG,    // Software configured card
  output logic [7:0]       CFG_A,       // Config byte A
  output logic [7:0]       CFG_B,       // Config byte B
  output logic [7:0]       CFG_C,       // Config byte C
  output logic [7:0]       CFG_D,       // Config byte D
  output logic [47:0]      STATION_ADDR, // Station address
  output logic [31:0]      VENDOR_ID,   // Vendor identifier
  output logic [31:0]      SERIAL_NUM,  // Serial number
  output logic [7:0]       RES_CKSUM    // Resource checksum
);
  ipc_pkg::ipc_state_e state_q, state_d;
  ipc_pkg::ipc_mode_e  mode_q, mode_d;
  logic [7:0]  csn_q, csn_d;
  logic        act_q, act_d;
  logic        hcfg_q, hcfg_d;
  logic        vwake_q, vwake_d;
  logic [7:0]  cfg_q [4];
  logic [7:0]  cfg_d [4];
  logic [47:0] sta_q, sta_d;
  logic [31:0] vid_q, vid_d;
  logic [31:0] ser_q, ser_d;
  logic [7:0]  ck_q, ck_d;
  logic        std_hit, vnd_hit, armed;
  logic        w_valid, ld_done;
  logic [5:0]  w_addr;
  logic [15:0] w_data;
  logic        std_ok, cfg_ok, cmd_ok;

  // --------------------------------------------------------------
  // Key recognisers and EEPROM fetcher
  // --------------------------------------------------------------
  // Keys are only listened for once the mode is known
  assign armed = (state_q == ipc_pkg::WAIT_KEY) && ld_done;

  ipc_key_match #(.SEED(`IPC_STD_SEED)) u_std_key (
    .clk  (REF_CLK),
    .rst  (RST),
    .arm  (armed),
    .wr   (ADDR_WR),
    .data (ADDR_DATA),
    .hit  (std_hit)
  );

  // Vendor key uses its own seed so only this family wakes
  ipc_key_match #(.SEED(`IPC_VND_SEED)) u_vnd_key (
    .clk  (REF_CLK),
    .rst  (RST),
    .arm  (armed),
    .wr   (ADDR_WR),
    .data (ADDR_DATA),
    .hit  (vnd_hit)
  );

  ipc_ee_loader u_ee (
    .clk       (REF_CLK),
    .rst       (RST),
    .ee_req    (EE_REQ),
    .ee_addr   (EE_ADDR),
    .ee_valid  (EE_VALID),
    .ee_data   (EE_DATA),
    .w_valid   (w_valid),
    .w_addr    (w_addr),
    .w_data    (w_data),
    .done      (ld_done),
    .res_req   (RES_REQ),      // RL13
    .res_idx   (RES_IDX),
    .res_valid (RES_VALID),
    .res_data  (RES_DATA)
  );

  // --------------------------------------------------------------
  // Permissions
  // --------------------------------------------------------------
  assign std_ok = (mode_q != ipc_pkg::MODE_JL);                 // RL14
  assign cfg_ok = vwake_q || (mode_q != ipc_pkg::MODE_JL);      // RL8
  assign cmd_ok = (state_q != ipc_pkg::WAIT_KEY);               // RL10

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  // Wait-for-key wins the next state in the same cycle; number and config writes still land
  always_comb
  begin
    state_d = state_q;
    mode_d  = mode_q;
    csn_d   = csn_q;
    act_d   = act_q;
    hcfg_d  = hcfg_q;
    vwake_d = vwake_q;
    cfg_d   = cfg_q;
    sta_d   = sta_q;
    vid_d   = vid_q;
    ser_d   = ser_q;
    ck_d    = ck_q;
    // Boot words land only in the run that follows a reset
    if (w_valid)
    begin
      case (w_addr)
        `IPC_EE_STA0:  sta_d[15:0]  = w_data;                   // RL16
        `IPC_EE_STA0 + 6'h01: sta_d[31:16] = w_data;            // RL16
        `IPC_EE_STA2:  sta_d[47:32] = w_data;                   // RL16
        `IPC_EE_CFGAB:
        begin
          cfg_d[0] = w_data[7:0];                               // RL16
          cfg_d[1] = w_data[15:8];
        end
        `IPC_EE_MODE:
        begin
          cfg_d[2] = w_data[7:0];                               // RL16
          if (w_data[15:8] == `IPC_MODE_JL)                     // RL5
            mode_d = ipc_pkg::MODE_JL;
          else if (w_data[15:8] == `IPC_MODE_PNP)
            mode_d = ipc_pkg::MODE_PNP;
          else
            mode_d = ipc_pkg::MODE_AUTO;
          // Pnp starts disabled; others run from EEPROM at once
          act_d = (w_data[15:8] != `IPC_MODE_PNP);              // RL9 RL7
        end
        `IPC_EE_VID0:  vid_d[15:0]  = w_data;                   // RL12
        `IPC_EE_VID1:  vid_d[31:16] = w_data;                   // RL12
        `IPC_EE_SER0:  ser_d[15:0]  = w_data;                   // RL12
        `IPC_EE_SER1:  ser_d[31:16] = w_data;                   // RL12
        `IPC_EE_CKSUM: ck_d = w_data[7:0];                      // RL12
        default: ;
      endcase
    end
    case (state_q)
      ipc_pkg::WAIT_KEY:
      begin
        if (vnd_hit)                                            // RL11
        begin
          state_d = ipc_pkg::SLEEP;
          vwake_d = 1'b1;
        end
        else if (std_hit && std_ok)                             // RL11
        begin
          state_d = ipc_pkg::SLEEP;
          vwake_d = 1'b0;
        end
      end
      ipc_pkg::SLEEP, ipc_pkg::ISOLATE, ipc_pkg::CONFIG:
      begin
        if (CMD_WAKE)                                           // RL17
        begin
          if (CMD_DATA == `IPC_CSN_NONE && csn_q == `IPC_CSN_NONE)
            state_d = ipc_pkg::ISOLATE;
          else if (CMD_DATA == csn_q)
            state_d = ipc_pkg::CONFIG;
          else
            state_d = ipc_pkg::SLEEP;
        end
        else if (state_q == ipc_pkg::ISOLATE && CMD_SET_CSN)    // RL17
        begin
          csn_d   = CMD_DATA;
          state_d = ipc_pkg::CONFIG;
        end
        else if (state_q == ipc_pkg::ISOLATE && ISO_LOST)       // RL17
          state_d = ipc_pkg::SLEEP;
        else if (state_q == ipc_pkg::CONFIG)
        begin
          if (CFG_WR && cfg_ok)                                 // RL15
          begin
            cfg_d[CFG_IDX] = CFG_DATA;
            hcfg_d = 1'b1;                                      // RL7
          end
          if (ACT_WR && cfg_ok)                                 // RL9
          begin
            act_d  = ACT_DATA;
            hcfg_d = 1'b1;
          end
        end
        if (CMD_RST_STD || CMD_RST_VND)                         // RL4
          csn_d = `IPC_CSN_NONE;
        if (CMD_WAIT_KEY)                                       // RL3
          state_d = ipc_pkg::WAIT_KEY;
      end
      default: state_d = ipc_pkg::WAIT_KEY;
    endcase
  end

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  // Reset restores EEPROM values; software settings are lost here
  always_ff @(posedge REF_CLK)
  begin
    if (RST)                                                    // RL2
    begin
      state_q <= ipc_pkg::WAIT_KEY;
      mode_q  <= ipc_pkg::MODE_JL;
      csn_q   <= `IPC_CSN_NONE;
      act_q   <= 1'b0;
      hcfg_q  <= 1'b0;
      vwake_q <= 1'b0;
      cfg_q   <= '{8'h00, 8'h00, 8'h00, `IPC_CFGD_RST};
      sta_q   <= 48'h000000000000;
      vid_q   <= 32'h00000000;
      ser_q   <= 32'h00000000;
      ck_q    <= 8'h00;
    end
    else
    begin
      state_q <= state_d;                                       // RL1
      mode_q  <= mode_d;                                        // RL6
      csn_q   <= csn_d;
      act_q   <= act_d;
      hcfg_q  <= hcfg_d;
      vwake_q <= vwake_d;
      cfg_q   <= cfg_d;
      sta_q   <= sta_d;
      vid_q   <= vid_d;
      ser_q   <= ser_d;
      ck_q    <= ck_d;
    end
  end

  assign STATE        = state_q;
  assign CSN          = csn_q;
  assign MODE         = mode_q;
  assign LOAD_DONE    = ld_done;
  assign CFG_ACTIVE   = act_q;
  assign HOST_CFG     = hcfg_q;
  assign CFG_A        = cfg_q[0];
  assign CFG_B        = cfg_q[1];
  assign CFG_C        = cfg_q[2];
  assign CFG_D        = cfg_q[3];
  assign STATION_ADDR = sta_q;
  assign VENDOR_ID    = vid_q;
  assign SERIAL_NUM   = ser_q;
  assign RES_CKSUM    = ck_q;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  a_state_legal: assert property (@(posedge REF_CLK) disable iff (RST) // RL1
    state_q inside {ipc_pkg::WAIT_KEY, ipc_pkg::SLEEP,
                    ipc_pkg::ISOLATE, ipc_pkg::CONFIG})
    else $error("Card state left the four legal states");

  a_reset_wait: assert property (@(posedge REF_CLK) // RL2
    RST |=> state_q == ipc_pkg::WAIT_KEY && csn_q == `IPC_CSN_NONE)
    else $error("Reset did not give wait state and number zero");

  a_wait_cmd: assert property (@(posedge REF_CLK) disable iff (RST) // RL3
    cmd_ok && CMD_WAIT_KEY |=> state_q == ipc_pkg::WAIT_KEY)
    else $error("Wait-for-key command ignored");

  a_csn_clear: assert property (@(posedge REF_CLK) disable iff (RST) // RL4
    cmd_ok && (CMD_RST_STD || CMD_RST_VND) && !CMD_WAKE && !CMD_SET_CSN
    && !CMD_WAIT_KEY && !ISO_LOST
    |=> csn_q == `IPC_CSN_NONE && $stable(state_q))
    else $error("Number reset wrong or changed state");

  a_mode_decode: assert property (@(posedge REF_CLK) disable iff (RST) // RL5
    w_valid && w_addr == `IPC_EE_MODE && w_data[15:8] == `IPC_MODE_PNP
    |=> mode_q == ipc_pkg::MODE_PNP)
    else $error("Mode byte decoded wrong");

  a_mode_hold: assert property (@(posedge REF_CLK) disable iff (RST) // RL6
    ld_done |=> $stable(mode_q))
    else $error("Mode changed without a reset");

  a_jl_ignore: assert property (@(posedge REF_CLK) disable iff (RST) // RL8
    CFG_WR && mode_q == ipc_pkg::MODE_JL && !vwake_q |=> $stable(cfg_q[0])
    && $stable(cfg_q[1]) && $stable(cfg_q[3]))
    else $error("Jumperless card took standard configuration");

  a_pnp_off: assert property (@(posedge REF_CLK) disable iff (RST) // RL9
    $rose(ld_done) && mode_q == ipc_pkg::MODE_PNP |-> !act_q)
    else $error("Pnp card came up enabled");

  a_key_gate: assert property (@(posedge REF_CLK) disable iff (RST) // RL10
    state_q == ipc_pkg::WAIT_KEY && !std_hit && !vnd_hit
    |=> state_q == ipc_pkg::WAIT_KEY)
    else $error("Left wait state without a full key");

  a_std_block: assert property (@(posedge REF_CLK) disable iff (RST) // RL14
    armed && std_hit && !vnd_hit && mode_q == ipc_pkg::MODE_JL
    |=> state_q == ipc_pkg::WAIT_KEY)
    else $error("Standard key woke a jumperless card");
endmodule : ipc_card_cfg
`default_nettype wire

// File: tb/ipc_ee_model.sv
// Serial EEPROM stand-in answering word fetches of the card logic
`timescale 1ns/1ps
`default_nettype none
module ipc_ee_model (
  input  wire logic        clk,   // Device clock
  input  wire logic        req,   // Word request level
  input  wire logic [5:0]  addr,  // Word address
  input  wire logic        slow,  // Long answer delay
  input  wire logic [7:0]  mode,  // Mode byte held in word 0fh
  output logic             valid, // Word ready pulse
  output logic [15:0]      data   // Word
);
  logic [3:0] cnt_q;
  initial
  begin
    valid = 1'b0;
    data  = 16'h0000;
    cnt_q = 4'h0;
  end
  // Answer after a delay; idle data toggles so a stale word is never seen
  always @(posedge clk)
  begin
    valid <= 1'b0;
    data  <= ~data;
    if (!req || valid)
      cnt_q <= 4'h0;
    else if (cnt_q == (slow ? 4'h6 : 4'h1))
    begin
      cnt_q <= 4'h0;
      valid <= 1'b1;
      data  <= (addr == 6'h0f) ? {mode, 8'h0f}
                               : {~{2'h0, addr}, {2'h0, addr}};
    end
    else
      cnt_q <= cnt_q + 4'h1;
  end
endmodule : ipc_ee_model
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking testbench for the card configuration logic
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk, rst, awr, c_wk, c_rs, c_rv, c_wake, c_set, iso;
  logic        cwr, act, act_d, rreq, slow, ee_v, ee_req, res_v;
  logic        done, cact, hcfg;
  logic [7:0]  ad, arg, cdat, mode_b, csn, ca, cb, cc, cd, ck;
  logic [1:0]  cidx, st, md;
  logic [5:0]  ridx, ee_a;
  logic [15:0] ee_d, res_d;
  logic [47:0] sta;
  logic [31:0] vid, ser;
  int          miscompares, samples_checked;

  ipc_card_cfg ipc_card_cfg_inst (.REF_CLK(clk), .RST(rst), .ADDR_WR(awr),
    .ADDR_DATA(ad), .CMD_WAIT_KEY(c_wk), .CMD_RST_STD(c_rs),
    .CMD_RST_VND(c_rv), .CMD_WAKE(c_wake), .CMD_SET_CSN(c_set),
    .CMD_DATA(arg), .ISO_LOST(iso), .CFG_WR(cwr), .CFG_IDX(cidx),
    .CFG_DATA(cdat), .ACT_WR(act), .ACT_DATA(act_d), .RES_REQ(rreq),
    .RES_IDX(ridx), .RES_VALID(res_v), .RES_DATA(res_d), .EE_REQ(ee_req),
    .EE_ADDR(ee_a), .EE_VALID(ee_v), .EE_DATA(ee_d), .STATE(st), .CSN(csn),
    .MODE(md), .LOAD_DONE(done), .CFG_ACTIVE(cact), .HOST_CFG(hcfg),
    .CFG_A(ca), .CFG_B(cb), .CFG_C(cc), .CFG_D(cd), .STATION_ADDR(sta),
    .VENDOR_ID(vid), .SERIAL_NUM(ser), .RES_CKSUM(ck));
  ipc_ee_model ipc_ee_model_inst (.clk(clk), .req(ee_req), .addr(ee_a),
    .slow(slow), .mode(mode_b), .valid(ee_v), .data(ee_d));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Word image the partner holds, apart from the mode word
  function automatic logic [15:0] w(input logic [5:0] a);
    w = {~{2'h0, a}, {2'h0, a}};
  endfunction : w

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  task automatic chk(input string n, input logic [47:0] e, logic [47:0] g);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Bounded wait on load done (k=0) or resource strobe (k=1)
  task automatic wait_hi(input int k);
    int i;
    for (i = 0; i < 300 && (k ? res_v : done) !== 1'b1; i++)
      @(negedge clk);
    chk("wait", 1, k ? res_v : done);
    if ((k ? res_v : done) !== 1'b1)
      wrap_up();
  endtask : wait_hi

  // One-cycle strobe; an idle cycle follows so the answer has landed
  task automatic cmd(input int k, input logic [7:0] a, input logic [5:0] b);
    @(negedge clk);
    {arg, ad, cdat, act_d, cidx, ridx} = {a, a, a, a[0], b[1:0], b};
    case (k)
      0: c_wk = 1'b1;
      1: c_rs = 1'b1;
      2: c_rv = 1'b1;
      3: c_wake = 1'b1;
      4: c_set = 1'b1;
      5: cwr = 1'b1;
      6: act = 1'b1;
      7: awr = 1'b1;
      8: rreq = 1'b1;
      default: iso = 1'b1;
    endcase
    @(negedge clk);
    {c_wk, c_rs, c_rv, c_wake, c_set, cwr, act, awr, rreq, iso} = '0;
    @(negedge clk);
  endtask : cmd

  // Address-port run of n bytes from a seed
  task automatic key(input logic [7:0] seed, input int n);
    logic [7:0] b;
    b = seed;
    repeat (n)
    begin
      cmd(7, b, 6'h00);
      b = {b[1] ^ b[0], b[7:1]};
    end
  endtask : key

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic sc_boot(input logic [7:0] m, input logic [1:0] em,
                         input logic ea);
    mode_b = m;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    chk("state", ipc_pkg::WAIT_KEY, st);
    chk("csn", 0, csn);
    rst = 1'b0;
    wait_hi(0);
    @(negedge clk);
    chk("mode", em, md);
    chk("station", {w(2), w(1), w(0)}, sta);
    chk("cfg", {8'h0f, 8'hf1, 8'h0e}, {cc, cb, ca});
    chk("vid", {w(6'h11), w(6'h10)}, vid);
    chk("serial", {w(6'h13), w(6'h12)}, ser);
    chk("cksum", 8'h14, ck);
    chk("active", ea, cact);
  endtask : sc_boot

  task automatic sc_jumperless;
    key(`IPC_VND_SEED, 31);
    chk("part key", ipc_pkg::WAIT_KEY, st);
    sc_boot(8'h4a, ipc_pkg::MODE_JL, 1'b1);
    key(`IPC_STD_SEED, 32);
    chk("std key", ipc_pkg::WAIT_KEY, st);
    cmd(5, 8'h77, 6'h00);
    chk("jl cfg", 8'h0e, ca);
    cmd(3, 8'h00, 6'h00);
    chk("no cmd", ipc_pkg::WAIT_KEY, st);
    key(`IPC_VND_SEED, 32);
    chk("vnd key", ipc_pkg::SLEEP, st);
    cmd(3, 8'h00, 6'h00);
    chk("isolate", ipc_pkg::ISOLATE, st);
    cmd(4, 8'h05, 6'h00);
    chk("csn set", 8'h05, csn);
    cmd(3, 8'h05, 6'h00);
    chk("config", ipc_pkg::CONFIG, st);
    cmd(5, 8'ha5, 6'h01);
    chk("cfg b", 8'ha5, cb);
    cmd(1, 8'h00, 6'h00);
    chk("std rst", {ipc_pkg::CONFIG, 8'h00}, {st, csn});
    cmd(0, 8'h00, 6'h00);
    chk("wait cmd", ipc_pkg::WAIT_KEY, st);
  endtask : sc_jumperless

  task automatic sc_pnp;
    mode_b = 8'h50;
    repeat (4) @(negedge clk);
    chk("mode kept", ipc_pkg::MODE_JL, md);
    sc_boot(8'h50, ipc_pkg::MODE_PNP, 1'b0);
    key(`IPC_STD_SEED, 32);
    chk("std key", ipc_pkg::SLEEP, st);
    cmd(3, 8'h00, 6'h00);
    cmd(4, 8'h03, 6'h00);
    cmd(3, 8'h03, 6'h00);
    chk("config", {ipc_pkg::CONFIG, 8'h03}, {st, csn});
    cmd(6, 8'h01, 6'h00);
    chk("act", 1, cact);
    cmd(2, 8'h00, 6'h00);
    chk("vnd rst", {ipc_pkg::CONFIG, 8'h00}, {st, csn});
    cmd(5, 8'h3c, 6'h00);
    chk("cfg a", 8'h3c, ca);
  endtask : sc_pnp

  task automatic sc_auto;
    sc_boot(8'h00, ipc_pkg::MODE_AUTO, 1'b1);
    key(`IPC_STD_SEED, 32);
    chk("std key", ipc_pkg::SLEEP, st);
    cmd(3, 8'h00, 6'h00);
    cmd(9, 8'h00, 6'h00);
    chk("lost", ipc_pkg::SLEEP, st);
    slow = 1'b1;
    cmd(8, 8'h00, 6'h00);
    wait_hi(1);
    chk("res 15", w(6'h15), res_d);
    cmd(8, 8'h00, 6'h2a);
    wait_hi(1);
    chk("res 3f", w(6'h3f), res_d);
    slow = 1'b0;
    cmd(8, 8'h00, 6'h3f);
    wait_hi(1);
    chk("res clip", w(6'h3f), res_d);
  endtask : sc_auto

  // ----------------------------------------
  // Clock and main sequence
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial
  begin
    {awr, c_wk, c_rs, c_rv, c_wake, c_set, iso, cwr, act} = '0;
    {act_d, rreq, slow, ad, arg, cdat, cidx, ridx} = '0;
    miscompares = 0;
    samples_checked = 0;
    sc_boot(8'h4a, ipc_pkg::MODE_JL, 1'b1);
    sc_jumperless();
    sc_pnp();
    sc_auto();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
